/* hw/fsr_pkg.sv */
package fsr_pkg;
	// coprocessor register selectors (crn, crm, opc1, opc2)
	localparam logic [3:0] CRN_FAULT = 4'h5;
	localparam logic [3:0] CRM_FAULT = 4'h0;
	localparam logic [2:0] OPC1_FSR = 3'h0;
	localparam logic [2:0] OPC2_DATA_FAULT_STATUS = 3'h0;
	localparam logic [2:0] OPC2_INSTRUCTION_FAULT_STATUS = 3'h1;
	localparam logic [3:0] CRM_AUX = 4'h1;
	localparam logic [2:0] OPC1_HYP = 3'h4;
	localparam logic [3:0] CRN_SYND = 4'h5;
	localparam logic [3:0] CRM_SYND = 4'h2;
	localparam logic [2:0] OPC2_SYND = 3'h0;
	localparam logic [3:0] CRN_PAR = 4'h7;
	localparam logic [3:0] CRM_PAR = 4'h4;
	localparam logic [2:0] OPC2_PAR = 3'h0;
	// instruction fault status, long- and short-descriptor layouts
	localparam int IFS_EXT_POS = 12;
	localparam int IFS_RAO_POS = 9;
	localparam int IFS_SHORT_FS4_POS = 10;
	localparam logic [31:0] IFS_RESET = 32'h0000_0200;
	localparam logic [31:0] IFS_SHORT_RESET = 32'h0000_0000;
	localparam logic [5:0] ST_TRANS = 6'h04;
	localparam logic [5:0] ST_ACCESS = 6'h08;
	localparam logic [5:0] ST_PERM = 6'h0C;
	localparam logic [5:0] ST_SYNC_EXT = 6'h10;
	localparam logic [5:0] ST_DEBUG = 6'h22;
	localparam logic [1:0] LL_RESERVED = 2'h0;
	// hypervisor syndrome and address result layout
	localparam int HS_EC_LSB = 26;
	localparam int HS_IL_POS = 25;
	localparam int HS_CV_POS = 24;
	localparam int HS_CONDITION_CODE_LSB = 20;
	localparam logic [3:0] CONDITION_CODE_TRAPPED = 4'hE;
	localparam logic [31:0] HS_RESET = 32'h0000_0000;
	localparam logic [63:0] PAR_RESET = 64'h0;
	localparam int PAR_UNK_POS = 8;
	// processor modes
	localparam logic [4:0] MODE_MON = 5'h16;
	localparam logic [4:0] MODE_HYP = 5'h1A;
	// fault kinds reported by the translation logic
	typedef enum logic [2:0] {
		FK_TRANS = 3'b000,
		FK_ACCESS = 3'b001,
		FK_PERM = 3'b010,
		FK_EXT = 3'b011,
		FK_DEBUG = 3'b100
	} fsr_kind_t;
endpackage

/* hw/fsr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - external abort: abort type bit 12 is 0 for decode error, 1 for slave error
// - non-external faults return 0 in the abort type bit
// - long status: translation 0001LL, access flag 0010LL, permission 0011LL
// - synchronous external abort 010000, debug 100010; other codes reserved
// - level bits: 01 level 1, 10 level 2, 11 level 3; 00 reserved
// - cache maintenance abort reported in data fault status or syndrome
// - after such a report in data fault status, instruction status unspecified
// - instruction fault status at opc1 0, c5, c0, opc2 1, read and write
// - auxiliary fault status registers unimplemented: read unknown, writes ignored
// - syndrome accessible only in hyp mode or monitor with nonsecure bit set
// - syndrome content unspecified in nonsecure modes other than hyp
// - syndrome: class 31:26, length 25, specific syndrome 24:0
// - nonzero class with top bits 00 carries valid flag and condition 24:20
// - trapped instruction sets condition valid bit 24 to 1
// - trapped instruction writes condition code 0xE
// - condition code unknown while valid flag is 0; writes preserved
// - address result has no extra bits; bit 8 unknown, writes ignored
// - instruction status layout follows the active table format
// - instruction status holds last fault, banked secure and nonsecure
module fsr_regs #(
	parameter int DATA_W = 32
) (
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	// coprocessor access port
	input wire logic i_cp_valid,
	input wire logic i_cp_write,
	input wire logic [2:0] i_cp_opc1,
	input wire logic [3:0] i_cp_crn,
	input wire logic [3:0] i_cp_crm,
	input wire logic [2:0] i_cp_opc2,
	input wire logic [DATA_W-1:0] i_cp_wdata,
	input wire logic [4:0] i_mode,
	input wire logic i_nonsecure,
	input wire logic i_secure_config_nonsecure_bit,
	input wire logic i_long_desc,
	// instruction fault capture
	input wire logic i_ifault,
	input wire fsr_pkg::fsr_kind_t i_ifault_kind,
	input wire logic [1:0] i_ifault_level,
	input wire logic i_ifault_slverr,
	// data fault status word and cache maintenance faults
	input wire logic i_dfault,
	input wire logic [DATA_W-1:0] i_dfault_status,
	input wire logic i_cmaint_fault,
	input wire logic i_cmaint_to_hyp,
	// hyp exception capture
	input wire logic i_hyp_exc,
	input wire logic [5:0] i_hyp_class,
	input wire logic i_hyp_len,
	input wire logic [24:0] i_hyp_iss,
	input wire logic i_hyp_trapped,
	input wire logic [3:0] i_hyp_condition_code,
	// address translation result
	input wire logic i_par_load,
	input wire logic [63:0] i_par_value,
	output logic [DATA_W-1:0] O_CP_RDATA,
	output logic O_CP_ACK,
	output logic O_CP_UNDEF,
	output logic [DATA_W-1:0] O_DATA_FAULT_STATUS,
	output logic O_IFS_UNKNOWN
);
	typedef struct packed {
		logic [DATA_W-1:0] ifs_s;
		logic [DATA_W-1:0] ifs_ns;
		logic [DATA_W-1:0] dfs;
		logic [DATA_W-1:0] hs;
		logic [63:0] par;
		logic ifs_unk;
		logic [DATA_W-1:0] rdata;
		logic ack;
		logic undef;
	} fsr_state_t;

	fsr_state_t st_q;
	fsr_state_t st_d;
	logic [31:0] enc_word;
	logic enc_valid;
	logic sel_ifs, sel_dfs, sel_aux, sel_haux, sel_hs, sel_par;
	logic hs_allowed;
	logic [DATA_W-1:0] ifs_cur;
	logic [DATA_W-1:0] hs_new;
	logic [31:0] ifs_wmask;

	fsr_status_enc u_enc (
		.i_long(i_long_desc),
		.i_kind(i_ifault_kind),
		.i_level(i_ifault_level),
		.i_slverr(i_ifault_slverr),
		.o_word(enc_word),
		.o_valid(enc_valid)
	);

	// register decode
	assign sel_ifs = i_cp_opc1 == fsr_pkg::OPC1_FSR && i_cp_crn == fsr_pkg::CRN_FAULT &&
		i_cp_crm == fsr_pkg::CRM_FAULT && i_cp_opc2 == fsr_pkg::OPC2_INSTRUCTION_FAULT_STATUS;
	assign sel_dfs = i_cp_opc1 == fsr_pkg::OPC1_FSR && i_cp_crn == fsr_pkg::CRN_FAULT &&
		i_cp_crm == fsr_pkg::CRM_FAULT && i_cp_opc2 == fsr_pkg::OPC2_DATA_FAULT_STATUS;
	assign sel_aux = i_cp_opc1 == fsr_pkg::OPC1_FSR && i_cp_crn == fsr_pkg::CRN_FAULT &&
		i_cp_crm == fsr_pkg::CRM_AUX && i_cp_opc2[2:1] == 2'h0;
	assign sel_haux = i_cp_opc1 == fsr_pkg::OPC1_HYP && i_cp_crn == fsr_pkg::CRN_FAULT &&
		i_cp_crm == fsr_pkg::CRM_AUX && i_cp_opc2[2:1] == 2'h0;
	assign sel_hs = i_cp_opc1 == fsr_pkg::OPC1_HYP && i_cp_crn == fsr_pkg::CRN_SYND &&
		i_cp_crm == fsr_pkg::CRM_SYND && i_cp_opc2 == fsr_pkg::OPC2_SYND;
	assign sel_par = i_cp_opc1 == fsr_pkg::OPC1_FSR && i_cp_crn == fsr_pkg::CRN_PAR &&
		i_cp_crm == fsr_pkg::CRM_PAR && i_cp_opc2 == fsr_pkg::OPC2_PAR;

	// syndrome gate: hyp, or monitor while nonsecure bit set
	assign hs_allowed = (i_mode == fsr_pkg::MODE_HYP) ||
		(i_mode == fsr_pkg::MODE_MON && i_secure_config_nonsecure_bit);

	// banked copy seen by the current security state
	assign ifs_cur = i_nonsecure ? st_q.ifs_ns : st_q.ifs_s;

	// writable bits depend on format; long keeps reserved bits clear
	assign ifs_wmask = i_long_desc ? 32'h0000_103F : 32'h0000_140F;

	// assemble syndrome for a hyp exception
	always_comb begin
		hs_new = {i_hyp_class, i_hyp_len, i_hyp_iss};
		if (i_hyp_class != 6'h00 && i_hyp_class[5:4] == 2'h0) begin
			if (i_hyp_trapped) begin
				hs_new[fsr_pkg::HS_CV_POS] = 1'b1;
				hs_new[fsr_pkg::HS_CONDITION_CODE_LSB +: 4] = fsr_pkg::CONDITION_CODE_TRAPPED;
			end else begin
				hs_new[fsr_pkg::HS_CV_POS] = 1'b0;
				hs_new[fsr_pkg::HS_CONDITION_CODE_LSB +: 4] = i_hyp_condition_code;
			end
		end
	end

	// next-state: captures first, then software writes, then read answer
	always_comb begin
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.undef = 1'b0;
		st_d.rdata = '0;
		// fault capture records the latest instruction fault in the active bank
		if (i_ifault && enc_valid) begin
			if (i_nonsecure) begin
				st_d.ifs_ns = enc_word;
			end else begin
				st_d.ifs_s = enc_word;
			end
			st_d.ifs_unk = 1'b0;
		end
		if (i_dfault) begin
			st_d.dfs = i_dfault_status;
		end
		// cache maintenance abort goes to data status unless routed to hyp
		if (i_cmaint_fault) begin
			if (!i_cmaint_to_hyp) begin
				st_d.dfs = i_dfault_status;
				st_d.ifs_unk = 1'b1;
			end
		end
		if (i_hyp_exc) begin
			st_d.hs = hs_new;
		end
		if (i_par_load) begin
			st_d.par = i_par_value;
			st_d.par[fsr_pkg::PAR_UNK_POS] = 1'b0;
		end
		// software access
		if (i_cp_valid) begin
			st_d.ack = 1'b1;
			if (sel_ifs) begin
				if (i_cp_write) begin
					if (i_nonsecure) begin
						st_d.ifs_ns = (i_cp_wdata & ifs_wmask) |
							(i_long_desc ? fsr_pkg::IFS_RESET : fsr_pkg::IFS_SHORT_RESET);
					end else begin
						st_d.ifs_s = (i_cp_wdata & ifs_wmask) |
							(i_long_desc ? fsr_pkg::IFS_RESET : fsr_pkg::IFS_SHORT_RESET);
					end
					st_d.ifs_unk = 1'b0;
				end else begin
					st_d.rdata = ifs_cur;
					// long layout always shows bit 9 set, even over a short-format capture
					if (i_long_desc) begin
						st_d.rdata[fsr_pkg::IFS_RAO_POS] = 1'b1;
					end
				end
			end else if (sel_dfs) begin
				if (i_cp_write) begin
					st_d.dfs = i_cp_wdata;
				end else begin
					st_d.rdata = st_q.dfs;
				end
			end else if (sel_aux || sel_haux) begin
				// unimplemented: reads return zero, writes dropped
				st_d.rdata = '0;
				st_d.undef = sel_haux && !hs_allowed;
			end else if (sel_hs) begin
				if (!hs_allowed) begin
					st_d.undef = 1'b1;
				end else if (i_cp_write) begin
					st_d.hs = i_cp_wdata;
					// condition code preserved while valid flag is clear
					if (!i_cp_wdata[fsr_pkg::HS_CV_POS]) begin
						st_d.hs[fsr_pkg::HS_CONDITION_CODE_LSB +: 4] = st_q.hs[fsr_pkg::HS_CONDITION_CODE_LSB +: 4];
					end
				end else begin
					st_d.rdata = st_q.hs;
				end
			end else if (sel_par) begin
				if (i_cp_write) begin
					st_d.par[31:0] = i_cp_wdata;
					st_d.par[fsr_pkg::PAR_UNK_POS] = st_q.par[fsr_pkg::PAR_UNK_POS];
				end else begin
					st_d.rdata = st_q.par[31:0];
				end
			end else begin
				st_d.undef = 1'b1; // unmapped selector
			end
		end
	end

	// single state register; reset gives long-format bit 9 set
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			st_q.ifs_s <= fsr_pkg::IFS_RESET;
			st_q.ifs_ns <= fsr_pkg::IFS_RESET;
			st_q.dfs <= '0;
			st_q.hs <= fsr_pkg::HS_RESET;
			st_q.par <= fsr_pkg::PAR_RESET;
			st_q.ifs_unk <= 1'b0;
			st_q.rdata <= '0;
			st_q.ack <= 1'b0;
			st_q.undef <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign O_CP_RDATA = st_q.rdata;
	assign O_CP_ACK = st_q.ack;
	assign O_CP_UNDEF = st_q.undef;
	assign O_DATA_FAULT_STATUS = st_q.dfs;
	assign O_IFS_UNKNOWN = st_q.ifs_unk;
endmodule
`default_nettype wire

/* hw/fsr_status_enc.sv */
`timescale 1ns/1ps
`default_nettype none
// builds the instruction fault status word for one fault
module fsr_status_enc (
	input wire logic i_long,
	input wire fsr_pkg::fsr_kind_t i_kind,
	input wire logic [1:0] i_level,
	input wire logic i_slverr,
	output logic [31:0] o_word,
	output logic o_valid
);
	logic [5:0] status;
	logic [4:0] short_fs;

	// long format status codes, level folded into low bits
	always_comb begin
		o_valid = 1'b1;
		status = fsr_pkg::ST_SYNC_EXT;
		short_fs = 5'h08;
		unique case (i_kind)
			fsr_pkg::FK_TRANS: begin
				status = fsr_pkg::ST_TRANS | {4'h0, i_level};
				short_fs = 5'h05;
			end
			fsr_pkg::FK_ACCESS: begin
				status = fsr_pkg::ST_ACCESS | {4'h0, i_level};
				short_fs = 5'h03;
			end
			fsr_pkg::FK_PERM: begin
				status = fsr_pkg::ST_PERM | {4'h0, i_level};
				short_fs = 5'h0D;
			end
			fsr_pkg::FK_EXT: begin
				status = fsr_pkg::ST_SYNC_EXT;
				short_fs = 5'h08;
			end
			fsr_pkg::FK_DEBUG: begin
				status = fsr_pkg::ST_DEBUG;
				short_fs = 5'h02;
			end
			default: o_valid = 1'b0; // reserved kind, nothing captured
		endcase
		// level 0b00 is reserved for the level-carrying kinds
		if (i_kind inside {fsr_pkg::FK_TRANS, fsr_pkg::FK_ACCESS, fsr_pkg::FK_PERM} &&
				i_level == fsr_pkg::LL_RESERVED) begin
			o_valid = 1'b0;
		end
		o_word = 32'h0000_0000;
		if (i_long) begin
			o_word[5:0] = status;
			o_word[fsr_pkg::IFS_RAO_POS] = 1'b1;
		end else begin
			o_word[3:0] = short_fs[3:0];
			o_word[fsr_pkg::IFS_SHORT_FS4_POS] = short_fs[4];
		end
		// abort type only meaningful for external aborts
		o_word[fsr_pkg::IFS_EXT_POS] = (i_kind == fsr_pkg::FK_EXT) ? i_slverr : 1'b0;
	end
endmodule
`default_nettype wire

/* sim/fsr_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the fault and syndrome register block
module fsr_regs_monitor #(
	parameter int DATA_W = 32
) (
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	input wire logic i_cp_valid,
	input wire logic i_cp_write,
	input wire logic [2:0] i_cp_opc1,
	input wire logic [3:0] i_cp_crn,
	input wire logic [3:0] i_cp_crm,
	input wire logic [2:0] i_cp_opc2,
	input wire logic [4:0] i_mode,
	input wire logic i_secure_config_nonsecure_bit,
	input wire logic i_long_desc,
	input wire logic i_ifault,
	input wire logic i_dfault,
	input wire logic i_cmaint_fault,
	input wire logic i_cmaint_to_hyp,
	input wire logic [DATA_W-1:0] O_CP_RDATA,
	input wire logic O_CP_ACK,
	input wire logic O_CP_UNDEF,
	input wire logic O_IFS_UNKNOWN
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);
	// selector decodes shared by several checks
	logic rd;
	logic [13:0] sel;
	logic hyp_ok;
	assign rd = i_cp_valid && !i_cp_write;
	assign sel = {i_cp_opc1, i_cp_crn, i_cp_crm, i_cp_opc2};
	assign hyp_ok = i_mode == 5'h1A || (i_mode == 5'h16 && i_secure_config_nonsecure_bit);
	ack_one_cycle_a: assert property (i_cp_valid |=> O_CP_ACK)
		else $error("no acknowledge one cycle after request");
	ack_spurious_a: assert property (!i_cp_valid |=> !O_CP_ACK && !O_CP_UNDEF)
		else $error("acknowledge without request");
	rdata_idle_a: assert property (!O_CP_ACK |-> O_CP_RDATA == '0)
		else $error("read data not zero outside acknowledge");
	syn_refused_a: assert property (i_cp_valid && sel == 14'h2290 && !hyp_ok |=> O_CP_UNDEF)
		else $error("syndrome access not refused");
	syn_allowed_a: assert property (i_cp_valid && sel == 14'h2290 && hyp_ok |=> !O_CP_UNDEF)
		else $error("syndrome access refused in allowed mode");
	ifs_bit9_a: assert property (rd && sel == 14'h0281 && i_long_desc |=> O_CP_RDATA[9])
		else $error("long format status bit 9 not one");
	aux_zero_a: assert property (rd && sel[13:1] == 13'h0144 |=> O_CP_RDATA == '0)
		else $error("auxiliary status read not zero");
	par_bit8_a: assert property (rd && sel == 14'h03A0 |=> !O_CP_RDATA[8])
		else $error("address result bit 8 set");
	ifs_unknown_a: assert property (i_dfault && i_cmaint_fault && !i_cmaint_to_hyp
		&& !i_ifault && !i_cp_valid |=> O_IFS_UNKNOWN)
		else $error("instruction status not flagged unknown");
endmodule
`default_nettype wire

/* sim/tb_fsr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fsr_regs;
	logic I_CLK_SYS = 1'b0;
	logic I_SYS_RST = 1'b1;
	logic i_cp_valid, i_cp_write, i_nonsecure, i_secure_config_nonsecure_bit, i_long_desc;
	logic [2:0] i_cp_opc1, i_cp_opc2;
	logic [3:0] i_cp_crn, i_cp_crm, i_hyp_condition_code;
	logic [31:0] i_cp_wdata, i_dfault_status, O_CP_RDATA, O_DATA_FAULT_STATUS, rd, wd;
	logic [4:0] i_mode;
	logic i_ifault, i_ifault_slverr, i_dfault, i_cmaint_fault, i_cmaint_to_hyp;
	logic i_hyp_exc, i_hyp_len, i_hyp_trapped, i_par_load, O_CP_ACK, O_CP_UNDEF, O_IFS_UNKNOWN;
	fsr_pkg::fsr_kind_t i_ifault_kind;
	logic [1:0] i_ifault_level;
	logic [5:0] i_hyp_class;
	logic [24:0] i_hyp_iss;
	logic [63:0] i_par_value;
	logic ud;
	// last word expected in each bank: index 0 secure, 1 nonsecure
	logic [31:0] bank_exp [2];
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	fsr_regs u_fsr_regs (
		.I_CLK_SYS(I_CLK_SYS),
		.I_SYS_RST(I_SYS_RST),
		.i_cp_valid(i_cp_valid),
		.i_cp_write(i_cp_write),
		.i_cp_opc1(i_cp_opc1),
		.i_cp_crn(i_cp_crn),
		.i_cp_crm(i_cp_crm),
		.i_cp_opc2(i_cp_opc2),
		.i_cp_wdata(i_cp_wdata),
		.i_mode(i_mode),
		.i_nonsecure(i_nonsecure),
		.i_secure_config_nonsecure_bit(i_secure_config_nonsecure_bit),
		.i_long_desc(i_long_desc),
		.i_ifault(i_ifault),
		.i_ifault_kind(i_ifault_kind),
		.i_ifault_level(i_ifault_level),
		.i_ifault_slverr(i_ifault_slverr),
		.i_dfault(i_dfault),
		.i_dfault_status(i_dfault_status),
		.i_cmaint_fault(i_cmaint_fault),
		.i_cmaint_to_hyp(i_cmaint_to_hyp),
		.i_hyp_exc(i_hyp_exc),
		.i_hyp_class(i_hyp_class),
		.i_hyp_len(i_hyp_len),
		.i_hyp_iss(i_hyp_iss),
		.i_hyp_trapped(i_hyp_trapped),
		.i_hyp_condition_code(i_hyp_condition_code),
		.i_par_load(i_par_load),
		.i_par_value(i_par_value),
		.O_CP_RDATA(O_CP_RDATA),
		.O_CP_ACK(O_CP_ACK),
		.O_CP_UNDEF(O_CP_UNDEF),
		.O_DATA_FAULT_STATUS(O_DATA_FAULT_STATUS),
		.O_IFS_UNKNOWN(O_IFS_UNKNOWN)
	);
	always #5 I_CLK_SYS = ~I_CLK_SYS;
	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge I_CLK_SYS) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (n_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one coprocessor access; request held until the edge that takes it
	task automatic cp(input logic w, input logic [13:0] s, input logic [31:0] d);
		@(posedge I_CLK_SYS);
		i_cp_valid <= 1'b1;
		i_cp_write <= w;
		{i_cp_opc1, i_cp_crn, i_cp_crm, i_cp_opc2} <= s;
		i_cp_wdata <= d;
		@(posedge I_CLK_SYS);
		i_cp_valid <= 1'b0;
		#1;
		chk({31'h0, O_CP_ACK}, 32'h1);
		rd = O_CP_RDATA;
		ud = O_CP_UNDEF;
	endtask
	// one-cycle capture pulse: cmaint, dfault, par, hyp, ifault
	task automatic ev(input logic [4:0] m);
		@(posedge I_CLK_SYS);
		{i_cmaint_fault, i_dfault, i_par_load, i_hyp_exc, i_ifault} <= m;
		@(posedge I_CLK_SYS);
		{i_cmaint_fault, i_dfault, i_par_load, i_hyp_exc, i_ifault} <= 5'h00;
		#1;
	endtask
	function automatic logic [31:0] ifs_exp(fsr_pkg::fsr_kind_t k, logic [1:0] l, logic s);
		logic [5:0] st;
		case (k)
			fsr_pkg::FK_TRANS: st = fsr_pkg::ST_TRANS | {4'h0, l};
			fsr_pkg::FK_ACCESS: st = fsr_pkg::ST_ACCESS | {4'h0, l};
			fsr_pkg::FK_PERM: st = fsr_pkg::ST_PERM | {4'h0, l};
			fsr_pkg::FK_EXT: st = fsr_pkg::ST_SYNC_EXT;
			default: st = fsr_pkg::ST_DEBUG;
		endcase
		return {19'h0, k == fsr_pkg::FK_EXT && s, 2'h0, 1'b1, 3'h0, st};
	endfunction
	initial begin
		{i_cp_valid, i_cp_write, i_nonsecure, i_secure_config_nonsecure_bit} = 4'h0;
		{i_cp_opc1, i_cp_crn, i_cp_crm, i_cp_opc2, i_cp_wdata, i_hyp_condition_code} = '0;
		{i_ifault, i_ifault_slverr, i_dfault, i_cmaint_fault, i_cmaint_to_hyp} = 5'h00;
		{i_hyp_exc, i_hyp_len, i_hyp_trapped, i_par_load, i_hyp_class, i_hyp_iss} = '0;
		{i_ifault_level, i_dfault_status, i_par_value} = '0;
		i_ifault_kind = fsr_pkg::FK_TRANS;
		i_long_desc = 1'b1;
		i_mode = 5'h13;
		void'($urandom(4012));
		repeat (8) @(posedge I_CLK_SYS);
		I_SYS_RST <= 1'b0;
		cp(1'b0, 14'h0281, 32'h0);
		chk(rd, fsr_pkg::IFS_RESET);
		bank_exp[0] = fsr_pkg::IFS_RESET;
		bank_exp[1] = fsr_pkg::IFS_RESET;
		// random captures, bank chosen at random; level 00 must be dropped for translation, access flag and permission kinds
		repeat (24) begin
			wd = $urandom;
			i_nonsecure <= wd[0];
			i_ifault_kind <= fsr_pkg::fsr_kind_t'(wd[3:1] % 5);
			i_ifault_level <= 2'($urandom_range(3, 1));
			i_ifault_slverr <= wd[4];
			ev(5'h01);
			bank_exp[wd[0]] = ifs_exp(i_ifault_kind, i_ifault_level, i_ifault_slverr);
			cp(1'b0, 14'h0281, 32'h0);
			chk(rd, bank_exp[wd[0]]);
			i_nonsecure <= !wd[0];
			cp(1'b0, 14'h0281, 32'h0);
			chk(rd, bank_exp[!wd[0]]);
			i_nonsecure <= wd[0];
			i_ifault_level <= 2'h0;
			ev(5'h01);
			cp(1'b0, 14'h0281, 32'h0);
			chk(rd, bank_exp[wd[0]]);
		end
		// short-format capture: bit 9 clear in short layout, forced in long
		i_long_desc <= 1'b0;
		i_ifault_kind <= fsr_pkg::FK_TRANS;
		i_ifault_level <= 2'h1;
		ev(5'h01);
		cp(1'b0, 14'h0281, 32'h0);
		chk({31'h0, rd[9]}, 32'h0);
		i_long_desc <= 1'b1;
		cp(1'b0, 14'h0281, 32'h0);
		chk({31'h0, rd[9]}, 32'h1);
		// software write: reserved bits dropped, bit 9 kept
		wd = $urandom;
		cp(1'b1, 14'h0281, wd);
		cp(1'b0, 14'h0281, 32'h0);
		chk(rd, (wd & 32'h0000_103F) | fsr_pkg::IFS_RESET);
		// data status capture, then cache maintenance aborts to each target
		i_dfault_status <= wd;
		ev(5'h08);
		chk(O_DATA_FAULT_STATUS, wd);
		cp(1'b0, 14'h0280, 32'h0);
		chk(rd, wd);
		chk({31'h0, O_IFS_UNKNOWN}, 32'h0);
		i_dfault_status <= ~wd;
		ev(5'h18);
		chk(O_DATA_FAULT_STATUS, ~wd);
		chk({31'h0, O_IFS_UNKNOWN}, 32'h1);
		i_cmaint_to_hyp <= 1'b1;
		i_dfault_status <= wd;
		ev(5'h10);
		chk(O_DATA_FAULT_STATUS, ~wd);
		i_cmaint_to_hyp <= 1'b0;
		ev(5'h01);
		chk({31'h0, O_IFS_UNKNOWN}, 32'h0);
		// syndrome: refused outside hyp, then trapped and untrapped captures
		cp(1'b0, 14'h2290, 32'h0);
		chk({31'h0, ud}, 32'h1);
		i_mode <= fsr_pkg::MODE_HYP;
		wd = $urandom;
		i_hyp_class <= 6'h03;
		i_hyp_len <= wd[25];
		i_hyp_iss <= wd[24:0];
		i_hyp_trapped <= 1'b1;
		i_hyp_condition_code <= wd[3:0];
		ev(5'h02);
		cp(1'b0, 14'h2290, 32'h0);
		chk({31'h0, ud}, 32'h0);
		chk(rd, {6'h03, wd[25], 1'b1, fsr_pkg::CONDITION_CODE_TRAPPED, wd[19:0]});
		chk({28'h0, rd[23:20]}, {28'h0, fsr_pkg::CONDITION_CODE_TRAPPED});
		i_hyp_class <= 6'h24;
		i_hyp_trapped <= 1'b0;
		ev(5'h02);
		cp(1'b0, 14'h2290, 32'h0);
		chk(rd, {6'h24, wd[25], wd[24:0]});
		i_hyp_class <= 6'h03;
		ev(5'h02);
		cp(1'b0, 14'h2290, 32'h0);
		chk(rd, {6'h03, wd[25], 1'b0, wd[3:0], wd[19:0]});
		// write with the valid flag clear keeps the stored condition code
		cp(1'b1, 14'h2290, {wd[31:25], 1'b0, ~wd[3:0], wd[19:0]});
		cp(1'b0, 14'h2290, 32'h0);
		chk(rd, {wd[31:25], 1'b0, wd[3:0], wd[19:0]});
		i_mode <= fsr_pkg::MODE_MON;
		i_secure_config_nonsecure_bit <= 1'b1;
		cp(1'b0, 14'h2290, 32'h0);
		chk({31'h0, ud}, 32'h0);
		chk(rd, {wd[31:25], 1'b0, wd[3:0], wd[19:0]});
		i_secure_config_nonsecure_bit <= 1'b0;
		cp(1'b0, 14'h2290, 32'h0);
		chk({31'h0, ud}, 32'h1);
		cp(1'b0, 14'h2288, 32'h0);
		chk({31'h0, ud}, 32'h1);
		// auxiliary status: writes vanish, reads zero
		cp(1'b1, 14'h0289, wd);
		cp(1'b0, 14'h0289, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, ud}, 32'h0);
		// address result: bit 8 cleared on load, kept on write
		i_par_value <= {~wd, wd | 32'h0000_0100};
		ev(5'h04);
		cp(1'b0, 14'h03A0, 32'h0);
		chk(rd, wd & 32'hFFFF_FEFF);
		cp(1'b1, 14'h03A0, ~wd);
		cp(1'b0, 14'h03A0, 32'h0);
		chk(rd, ~wd & 32'hFFFF_FEFF);
		// unmapped selector is refused
		cp(1'b0, 14'h3FFF, 32'h0);
		chk({31'h0, ud}, 32'h1);
		give_verdict();
	end
endmodule
bind fsr_regs fsr_regs_monitor #(.DATA_W(DATA_W)) u_mon (
	.I_CLK_SYS(I_CLK_SYS),
	.I_SYS_RST(I_SYS_RST),
	.i_cp_valid(i_cp_valid),
	.i_cp_write(i_cp_write),
	.i_cp_opc1(i_cp_opc1),
	.i_cp_crn(i_cp_crn),
	.i_cp_crm(i_cp_crm),
	.i_cp_opc2(i_cp_opc2),
	.i_mode(i_mode),
	.i_secure_config_nonsecure_bit(i_secure_config_nonsecure_bit),
	.i_long_desc(i_long_desc),
	.i_ifault(i_ifault),
	.i_dfault(i_dfault),
	.i_cmaint_fault(i_cmaint_fault),
	.i_cmaint_to_hyp(i_cmaint_to_hyp),
	.O_CP_RDATA(O_CP_RDATA),
	.O_CP_ACK(O_CP_ACK),
	.O_CP_UNDEF(O_CP_UNDEF),
	.O_IFS_UNKNOWN(O_IFS_UNKNOWN)
);
`default_nettype wire
